/* logic/pm_access_pkg.sv */
// package: register map, field layout and timing constants of the program-memory access unit
package pm_access_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [7:0] OFF_FLASH_CONTROL = 8'h00;
    localparam logic [7:0] OFF_FLASH_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] OFF_CORE_CONTROL = 8'h08;
    localparam logic [7:0] OFF_WINDOW_PAGE = 8'h0C;
    localparam logic [7:0] OFF_TABLE_PAGE = 8'h10;
    // flash_control fields and the core control window enable bit
    localparam int FC_WRITE_START = 15;
    localparam int FC_WRITE_ENABLE = 14;
    localparam int FC_SEQ_ERROR = 13;
    localparam int FC_ERASE_SELECT = 6;
    localparam int FC_OP_LSB = 0;
    localparam logic [15:0] FC_RESET = 16'h0000;
    localparam int CC_WINDOW_ENABLE = 2;
    // operation codes
    localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_WORD_PROGRAM = 4'h3;
    localparam logic [3:0] OP_BULK_ERASE = 4'hF;
    // unlock key
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // array geometry
    localparam int ROW_WORDS = 64;
    localparam int PAGE_ROWS = 8;
    localparam int ROW_AW = 6;
    localparam int PAGE_AW = 9;
    localparam int PROG_AW = 24;
    localparam int PROG_DW = 24;
    // extra cycles for window reads
    localparam logic [1:0] WIN_EXTRA_MOVE = 2'h1;
    localparam logic [1:0] WIN_EXTRA_OTHER = 2'h2;
    // nominal operation time
    localparam int OP_TIME_US = 4000;
    localparam int CLK_MHZ = 50;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
endpackage : pm_access_pkg

/* logic/row_buffer_mem.sv */
// memory: 64-word holding buffer, registered read port
`timescale 1ns/1ps
module row_buffer_mem import pm_access_pkg::*; (
    // clock
    input wire logic clk_sys_i,
    input wire logic ce_i,
    // write port
    input wire logic wr_i,
    input wire logic [ROW_AW-1:0] waddr_i,
    input wire logic [PROG_DW-1:0] wdata_i,
    input wire logic [2:0] wmask_i,
    // read port
    input wire logic [ROW_AW-1:0] raddr_i,
    output logic [PROG_DW-1:0] rdata_o
);
    logic [PROG_DW-1:0] mem [ROW_WORDS];

    // per-byte write lanes
    for (genvar b = 0; b < 3; b++) begin : g_lane
        always_ff @(posedge clk_sys_i) begin
            if (ce_i && wr_i && wmask_i[b]) begin
                mem[waddr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : row_buffer_mem

/* logic/pm_access.sv */
// top: program-memory visibility window, table access path and self-programming sequencer
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pm_access import pm_access_pkg::*; #(
    parameter int OP_CYCLES_P = OP_CYCLES
) (
    // clock, enable, reset
    input wire logic clk_sys_i,
    input wire logic ce_i,
    input wire logic rstn_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // core data access
    input wire logic data_req_i,
    input wire logic [15:0] data_ea_i,
    input wire logic move_kind_i,
    input wire logic in_repeat_i,
    input wire logic rpt_edge_i,
    output logic win_hit_o,
    output logic [1:0] win_extra_o,
    output logic [15:0] win_data_o,
    output logic win_valid_o,
    // core table access
    input wire logic tbl_req_i,
    input wire logic tbl_write_i,
    input wire logic tbl_high_i,
    input wire logic tbl_byte_i,
    input wire logic [15:0] tbl_ea_i,
    input wire logic [15:0] tbl_wdata_i,
    output logic [15:0] tbl_rdata_o,
    output logic tbl_done_o,
    // program memory port
    output logic [PROG_AW-1:0] pm_addr_o,
    output logic pm_rd_o,
    input wire logic [PROG_DW-1:0] pm_rdata_i,
    output logic pm_wr_o,
    output logic [PROG_DW-1:0] pm_wdata_o,
    output logic pm_erase_o,
    output logic pm_bulk_o,
    // core stall
    output logic stall_o
);
    // =========================================================
    // register bus
    typedef enum logic [2:0] {ST_IDLE, ST_WIN2, ST_TBL, ST_OP, ST_PROG, ST_DONE} state_e;
    state_e st_r, st_nxt;
    logic [15:0] fc_r, fc_nxt;
    logic cc_win_r, cc_win_nxt;
    logic [7:0] wpage_r, wpage_nxt;
    logic [7:0] tpage_r, tpage_nxt;
    logic key_half_r, key_half_nxt;
    logic unlocked_r, unlocked_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic [PROG_AW-1:0] addr_r, addr_nxt;
    logic [PROG_AW-1:0] base_r, base_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [ROW_AW-1:0] idx_r, idx_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt, er_r, er_nxt, bulk_r, bulk_nxt;
    logic [PROG_DW-1:0] wdat_r, wdat_nxt;
    logic hit_r, hit_nxt, wval_r, wval_nxt, tdone_r, tdone_nxt;
    logic [1:0] extra_r, extra_nxt;
    logic [15:0] wdata_r, wdata_nxt, trd_r, trd_nxt;
    logic hi_r, hi_nxt, byte_r, byte_nxt, bsel_r, bsel_nxt;
    logic buf_wr;
    logic [2:0] buf_mask;
    logic [PROG_DW-1:0] buf_wdata, buf_rdata;
    logic [ROW_AW-1:0] buf_raddr;

    logic bus_req, bus_wr;
    logic [15:0] bus_wd;
    assign bus_req = cyc_i && stb_i && !ack_r;
    assign bus_wr = bus_req && we_i;
    assign bus_wd = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

    row_buffer_mem u_buf (
        .clk_sys_i(clk_sys_i),
        .ce_i(ce_i),
        .wr_i(buf_wr),
        .waddr_i(tbl_ea_i[ROW_AW:1]),
        .wdata_i(buf_wdata),
        .wmask_i(buf_mask),
        .raddr_i(buf_raddr),
        .rdata_o(buf_rdata)
    );

    // =========================================================
    // holding buffer write: table writes only touch the buffer
    always_comb begin
        buf_wr = (st_r == ST_IDLE) && tbl_req_i && tbl_write_i;
        buf_wdata = tbl_high_i ? {tbl_wdata_i[7:0], 16'h0000} : {8'h00, tbl_wdata_i};
        if (tbl_high_i) begin
            buf_mask = 3'b100;
        end else if (tbl_byte_i) begin
            buf_mask = tbl_ea_i[0] ? 3'b010 : 3'b001;
            buf_wdata = {8'h00, tbl_wdata_i[7:0], tbl_wdata_i[7:0]};
        end else begin
            buf_mask = 3'b011;
        end
        buf_raddr = idx_r;
    end

    // =========================================================
    // sequencer and registers
    always_comb begin
        st_nxt = st_r;
        fc_nxt = fc_r;
        cc_win_nxt = cc_win_r;
        wpage_nxt = wpage_r;
        tpage_nxt = tpage_r;
        key_half_nxt = key_half_r;
        unlocked_nxt = unlocked_r;
        dat_nxt = dat_r;
        ack_nxt = 1'b0;
        addr_nxt = addr_r;
        base_nxt = base_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        er_nxt = 1'b0;
        bulk_nxt = 1'b0;
        wdat_nxt = wdat_r;
        hit_nxt = 1'b0;
        wval_nxt = 1'b0;
        tdone_nxt = 1'b0;
        extra_nxt = extra_r;
        wdata_nxt = wdata_r;
        trd_nxt = trd_r;
        hi_nxt = hi_r;
        byte_nxt = byte_r;
        bsel_nxt = bsel_r;

        // bus access outside ST_OP and ST_PROG, answered one cycle after the request is seen
        if (bus_req && st_r != ST_OP && st_r != ST_PROG) begin
            ack_nxt = 1'b1;
            dat_nxt = 32'h0000_0000;
            if (bus_wr && adr_i != OFF_FLASH_UNLOCK_KEY) begin
                key_half_nxt = 1'b0;
            end
            unique case (adr_i)
                OFF_FLASH_CONTROL: begin
                    dat_nxt[15:0] = fc_r & 16'hE04F;
                    if (bus_wr) begin
                        fc_nxt = (bus_wd & 16'h404F) | (fc_r & (16'h1 << FC_SEQ_ERROR));
                        if (bus_wd[FC_WRITE_START]) begin
                            unlocked_nxt = 1'b0;
                            if (!unlocked_r || !bus_wd[FC_WRITE_ENABLE]) begin
                                fc_nxt[FC_SEQ_ERROR] = 1'b1;
                            end else begin
                                fc_nxt[FC_SEQ_ERROR] = 1'b0;
                                fc_nxt[FC_WRITE_START] = 1'b1;
                                st_nxt = ST_OP;
                                cnt_nxt = 32'(OP_CYCLES_P);
                                idx_nxt = '0;
                            end
                        end
                    end
                end
                OFF_FLASH_UNLOCK_KEY: begin
                    if (bus_wr) begin
                        if (bus_wd[7:0] == KEY_FIRST) begin
                            key_half_nxt = 1'b1;
                        end else begin
                            key_half_nxt = 1'b0;
                            unlocked_nxt = key_half_r && bus_wd[7:0] == KEY_SECOND;
                        end
                    end
                end
                OFF_CORE_CONTROL: begin
                    dat_nxt[CC_WINDOW_ENABLE] = cc_win_r;
                    if (bus_wr) cc_win_nxt = bus_wd[CC_WINDOW_ENABLE];
                end
                OFF_WINDOW_PAGE: begin
                    dat_nxt[7:0] = wpage_r;
                    if (bus_wr) wpage_nxt = bus_wd[7:0];
                end
                OFF_TABLE_PAGE: begin
                    dat_nxt[7:0] = tpage_r;
                    if (bus_wr) tpage_nxt = bus_wd[7:0];
                end
                default: dat_nxt = 32'h0000_0000;
            endcase
        end

        unique case (st_r)
            ST_IDLE: begin
                if (tbl_req_i) begin
                    // table path has priority: window suspended meanwhile
                    addr_nxt = {tpage_r, tbl_ea_i};
                    base_nxt = {tpage_r, tbl_ea_i};
                    hi_nxt = tbl_high_i;
                    byte_nxt = tbl_byte_i;
                    bsel_nxt = tbl_ea_i[0];
                    rd_nxt = !tbl_write_i;
                    st_nxt = ST_TBL;
                end else if (data_req_i && data_ea_i[15] && cc_win_r) begin
                    addr_nxt = {1'b0, wpage_r, data_ea_i[14:0]};
                    rd_nxt = 1'b1;
                    hit_nxt = 1'b1;
                    if (in_repeat_i) begin
                        extra_nxt = rpt_edge_i ? WIN_EXTRA_OTHER : WIN_EXTRA_MOVE;
                    end else begin
                        extra_nxt = move_kind_i ? WIN_EXTRA_MOVE : WIN_EXTRA_OTHER;
                    end
                    st_nxt = ST_WIN2;
                end
            end
            ST_WIN2: begin
                // second fetch cycle; low word only
                wdata_nxt = pm_rdata_i[15:0];
                wval_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            ST_TBL: begin
                if (hi_r) begin
                    trd_nxt = (byte_r && bsel_r) ? 16'h0000 : {8'h00, pm_rdata_i[23:16]};
                end else if (byte_r) begin
                    trd_nxt = {8'h00, bsel_r ? pm_rdata_i[15:8] : pm_rdata_i[7:0]};
                end else begin
                    trd_nxt = pm_rdata_i[15:0];
                end
                tdone_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            ST_OP: begin
                // operation decode from the latched control bits
                st_nxt = ST_DONE;
                if (fc_r[FC_ERASE_SELECT]) begin
                    if (fc_r[3:0] == OP_PAGE_ERASE) begin
                        addr_nxt = base_r & ~PROG_AW'((1 << (PAGE_AW + 1)) - 1);
                        er_nxt = 1'b1;
                        st_nxt = ST_PROG;
                    end else if (fc_r[3:0] == OP_BULK_ERASE) begin
                        bulk_nxt = 1'b1;
                        st_nxt = ST_PROG;
                    end
                end else if (fc_r[3:0] == OP_ROW_PROGRAM) begin
                    addr_nxt = base_r & ~PROG_AW'((1 << (ROW_AW + 1)) - 1);
                    idx_nxt = '0;
                    st_nxt = ST_PROG;
                end else if (fc_r[3:0] == OP_WORD_PROGRAM) begin
                    addr_nxt = {base_r[PROG_AW-1:1], 1'b0};
                    idx_nxt = base_r[ROW_AW:1];
                    st_nxt = ST_PROG;
                end
                // other codes go straight to done, array untouched
            end
            ST_PROG: begin
                if (cnt_r != 32'h0000_0000) cnt_nxt = cnt_r - 32'h0000_0001;
                if (!fc_r[FC_ERASE_SELECT] && cnt_r == 32'(OP_CYCLES_P) - 32'h0000_0001) begin
                    wr_nxt = 1'b1;
                    wdat_nxt = buf_rdata;
                end else if (!fc_r[FC_ERASE_SELECT] && wr_r && fc_r[3:0] == OP_ROW_PROGRAM
                             && idx_r != ROW_AW'(ROW_WORDS - 1)) begin
                    idx_nxt = idx_r + 1'b1;
                    addr_nxt = addr_r + PROG_AW'(2);
                end
                if (wr_r && fc_r[3:0] == OP_ROW_PROGRAM && idx_r != ROW_AW'(ROW_WORDS - 1)) begin
                    wr_nxt = 1'b0;
                    cnt_nxt = 32'(OP_CYCLES_P);
                end
                if (cnt_r == 32'h0000_0001) st_nxt = ST_DONE;
            end
            ST_DONE: begin
                fc_nxt[FC_WRITE_START] = 1'b0;
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= ST_IDLE;
            fc_r <= FC_RESET;
            cc_win_r <= 1'b0;
            wpage_r <= 8'h00;
            tpage_r <= 8'h00;
            key_half_r <= 1'b0;
            unlocked_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            addr_r <= '0;
            base_r <= '0;
            cnt_r <= 32'h0000_0000;
            idx_r <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            er_r <= 1'b0;
            bulk_r <= 1'b0;
            wdat_r <= '0;
            hit_r <= 1'b0;
            wval_r <= 1'b0;
            tdone_r <= 1'b0;
            extra_r <= 2'h0;
            wdata_r <= 16'h0000;
            trd_r <= 16'h0000;
            hi_r <= 1'b0;
            byte_r <= 1'b0;
            bsel_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            fc_r <= fc_nxt;
            cc_win_r <= cc_win_nxt;
            wpage_r <= wpage_nxt;
            tpage_r <= tpage_nxt;
            key_half_r <= key_half_nxt;
            unlocked_r <= unlocked_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            addr_r <= addr_nxt;
            base_r <= base_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            er_r <= er_nxt;
            bulk_r <= bulk_nxt;
            wdat_r <= wdat_nxt;
            hit_r <= hit_nxt;
            wval_r <= wval_nxt;
            tdone_r <= tdone_nxt;
            extra_r <= extra_nxt;
            wdata_r <= wdata_nxt;
            trd_r <= trd_nxt;
            hi_r <= hi_nxt;
            byte_r <= byte_nxt;
            bsel_r <= bsel_nxt;
        end
    end

    // =========================================================
    // outputs, all from flip-flops
    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign win_hit_o = hit_r;
    assign win_extra_o = extra_r;
    assign win_data_o = wdata_r;
    assign win_valid_o = wval_r;
    assign tbl_rdata_o = trd_r;
    assign tbl_done_o = tdone_r;
    assign pm_addr_o = addr_r;
    assign pm_rd_o = rd_r;
    assign pm_wr_o = wr_r;
    assign pm_wdata_o = wdat_r;
    assign pm_erase_o = er_r;
    assign pm_bulk_o = bulk_r;
    assign stall_o = fc_r[FC_WRITE_START];
endmodule : pm_access

/* test/pm_flash_model.sv */
// program flash array model on the far side of the memory port
`timescale 1ns/1ps
module pm_flash_model import pm_access_pkg::*; (
    // clock
    input wire logic clk_sys_i,
    // memory port
    input wire logic [PROG_AW-1:0] addr_i,
    input wire logic wr_i,
    input wire logic [PROG_DW-1:0] wdata_i,
    input wire logic erase_i,
    input wire logic bulk_i,
    output logic [PROG_DW-1:0] rdata_o
);
    // aliased 1024 words: bench addresses in other spans, such as window page 3 and table page 12, fold onto the same words
    logic [PROG_DW-1:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 24'h5A0000 | 24'(i);
        end
    end
    assign rdata_o = mem[addr_i[10:1]];
    always @(posedge clk_sys_i) begin
        if (wr_i) begin
            mem[addr_i[10:1]] <= wdata_i;
        end
        for (int i = 0; i < 1024; i++) begin
            if (bulk_i || (erase_i && i[9] == addr_i[10])) begin
                mem[i] <= 24'hFFFFFF;
            end
        end
    end
endmodule : pm_flash_model

/* test/pm_access_assertions.sv */
// port-level checks of the program-memory access unit
`timescale 1ns/1ps
module pm_access_assertions import pm_access_pkg::*; (
    // clock, reset, bus
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // core side
    input wire logic data_req_i,
    input wire logic [15:0] data_ea_i,
    input wire logic move_kind_i,
    input wire logic in_repeat_i,
    input wire logic rpt_edge_i,
    input wire logic win_hit_o,
    input wire logic [1:0] win_extra_o,
    input wire logic [15:0] win_data_o,
    input wire logic win_valid_o,
    input wire logic tbl_req_i,
    input wire logic tbl_write_i,
    input wire logic [15:0] tbl_ea_i,
    input wire logic tbl_done_o,
    // memory port
    input wire logic [PROG_AW-1:0] pm_addr_o,
    input wire logic pm_rd_o,
    input wire logic [PROG_DW-1:0] pm_rdata_i,
    input wire logic pm_wr_o,
    input wire logic pm_erase_o,
    input wire logic pm_bulk_o,
    input wire logic stall_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    win_miss_a: assert property (data_req_i && !data_ea_i[15] |=> !win_hit_o)
        else $error("window hit with address bit 15 clear");
    win_read_a: assert property (win_hit_o |=> win_valid_o && win_data_o == $past(pm_rdata_i[15:0]))
        else $error("window data late or not the low word");
    extra_plain_a: assert property (win_hit_o && !$past(in_repeat_i) |->
        win_extra_o == ($past(move_kind_i) ? WIN_EXTRA_MOVE : WIN_EXTRA_OTHER)) else $error("extra cycles wrong");
    extra_repeat_a: assert property (win_hit_o && $past(in_repeat_i) |->
        win_extra_o == ($past(rpt_edge_i) ? WIN_EXTRA_OTHER : WIN_EXTRA_MOVE)) else $error("repeat cycles wrong");
    tbl_block_a: assert property (tbl_req_i |=> !win_hit_o)
        else $error("window used during table access");
    tbl_done_a: assert property (tbl_req_i && !stall_o |-> ##2 tbl_done_o)
        else $error("table access not done in two cycles");
    tbl_addr_a: assert property (tbl_req_i && !tbl_write_i && !stall_o |=> pm_rd_o && pm_addr_o[15:0] == $past(tbl_ea_i))
        else $error("table read address wrong");
    op_bound_a: assert property ($rose(stall_o) |-> ##[1:1000] !stall_o)
        else $error("operation never ends");
    flash_gate_a: assert property (pm_wr_o || pm_erase_o || pm_bulk_o |-> stall_o)
        else $error("array changed outside an operation");
    ack_pulse_a: assert property (ack_o |-> $past(cyc_i && stb_i) ##1 !ack_o)
        else $error("ack without request or longer than one cycle");
endmodule : pm_access_assertions

bind pm_access pm_access_assertions i_pm_access_assertions (.clk_sys_i, .rstn_i, .cyc_i, .stb_i, .ack_o,
    .data_req_i, .data_ea_i, .move_kind_i, .in_repeat_i, .rpt_edge_i, .win_hit_o, .win_extra_o, .win_data_o,
    .win_valid_o, .tbl_req_i, .tbl_write_i, .tbl_ea_i, .tbl_done_o, .pm_addr_o, .pm_rd_o, .pm_rdata_i, .pm_wr_o,
    .pm_erase_o, .pm_bulk_o, .stall_o);

/* test/testbench.sv */
// self-checking bench of the program-memory access unit
`timescale 1ns/1ps
module testbench import pm_access_pkg::*;;
    logic clk_sys_i = 0, rstn_i = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, row_mode = 0;
    logic [7:0] adr_i = 8'h00, tpage = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd_q;
    logic data_req_i = 0, move_kind_i = 0, in_repeat_i = 0, rpt_edge_i = 0, tbl_req_i = 0;
    logic tbl_write_i = 0, tbl_high_i = 0, tbl_byte_i = 0, win_hit_o, win_valid_o, tbl_done_o;
    logic [15:0] data_ea_i = 16'h0, tbl_ea_i = 16'h0, tbl_wdata_i = 16'h0, win_data_o, tbl_rdata_o, q;
    logic pm_rd_o, pm_wr_o, pm_erase_o, pm_bulk_o, stall_o;
    logic [1:0] win_extra_o;
    logic [23:0] pm_addr_o, pm_rdata_i, pm_wdata_o;
    int n_mismatch = 0, samples_checked = 0, n_cyc = 0, n_wr = 0, n_er = 0, n_bk = 0;
    pm_access #(.OP_CYCLES_P(8)) i_pm_access (.clk_sys_i, .ce_i(1'b1), .rstn_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .data_req_i, .data_ea_i, .move_kind_i, .in_repeat_i, .rpt_edge_i,
        .win_hit_o, .win_extra_o, .win_data_o, .win_valid_o, .tbl_req_i, .tbl_write_i, .tbl_high_i, .tbl_byte_i,
        .tbl_ea_i, .tbl_wdata_i, .tbl_rdata_o, .tbl_done_o, .pm_addr_o, .pm_rd_o, .pm_rdata_i, .pm_wr_o,
        .pm_wdata_o, .pm_erase_o, .pm_bulk_o, .stall_o);
    pm_flash_model i_pm_flash_model (.clk_sys_i, .addr_i(pm_addr_o), .wr_i(pm_wr_o), .wdata_i(pm_wdata_o),
        .erase_i(pm_erase_o), .bulk_i(pm_bulk_o), .rdata_o(pm_rdata_i));
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] rq);
        @(posedge clk_sys_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do @(posedge clk_sys_i); while (ack_o !== 1'b1);
        rq = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb
    task automatic win(input logic [15:0] ea, input logic [2:0] k, input logic hit, input logic [1:0] extra);
        @(posedge clk_sys_i);
        data_req_i <= 1'b1;
        data_ea_i <= ea;
        {move_kind_i, in_repeat_i, rpt_edge_i} <= k;
        @(posedge clk_sys_i);
        data_req_i <= 1'b0;
        @(negedge clk_sys_i);
        check(32'(win_hit_o), 32'(hit));
        if (hit) begin
            check(32'(pm_addr_o), {9'h000, 8'h03, ea[14:0]});
            check(32'(win_extra_o), 32'(extra));
            @(negedge clk_sys_i);
            check(32'(win_valid_o), 32'h1);
            check(32'(win_data_o), {22'h0, ea[10:1]});
        end
    endtask : win
    task automatic tbl(input logic [2:0] k, input logic [15:0] ea, input logic [15:0] wd, output logic [15:0] rq);
        @(posedge clk_sys_i);
        tbl_req_i <= 1'b1;
        {tbl_write_i, tbl_high_i, tbl_byte_i} <= k;
        tbl_ea_i <= ea;
        tbl_wdata_i <= wd;
        data_req_i <= 1'b1;
        data_ea_i <= 16'h8200;
        @(posedge clk_sys_i);
        tbl_req_i <= 1'b0;
        data_req_i <= 1'b0;
        @(negedge clk_sys_i);
        check(32'(win_hit_o), 32'h0);
        if (!k[2]) check(32'(pm_addr_o), {8'h00, tpage, ea});
        @(negedge clk_sys_i);
        check(32'(tbl_done_o), 32'h1);
        rq = tbl_rdata_o;
    endtask : tbl
    // st: 00 no stall expected, 01 stall expected, 1x not judged
    task automatic op(input logic key, input logic [15:0] code, input logic [15:0] ctl, input logic [1:0] st);
        if (key) wb(1'b1, OFF_FLASH_UNLOCK_KEY, {8'h00, KEY_FIRST}, rd_q);
        if (key) wb(1'b1, OFF_FLASH_UNLOCK_KEY, {8'h00, KEY_SECOND}, rd_q);
        wb(1'b1, OFF_FLASH_CONTROL, code, rd_q);
        if (!st[1]) check(32'(stall_o), 32'(st[0]));
        repeat (2000) begin
            @(negedge clk_sys_i);
            if (stall_o === 1'b0) break;
        end
        wb(1'b0, OFF_FLASH_CONTROL, 16'h0, rd_q);
        check(rd_q, {16'h0, ctl});
    endtask : op
    // ==========================================
    // monitor and timeout
    always @(posedge clk_sys_i) begin
        n_cyc++;
        if (n_cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
        if (pm_wr_o === 1'b1 && row_mode) check(32'(pm_addr_o), 32'h0180 + 2 * n_wr);
        if (pm_wr_o === 1'b1 && row_mode) check(32'(pm_wdata_o), {8'h0, 8'hFF, 16'hA000 + n_wr[15:0]});
        if (pm_erase_o === 1'b1) check(32'(pm_addr_o[9:0]), 32'h0);
        if (pm_wr_o === 1'b1) n_wr++;
        if (pm_erase_o === 1'b1) n_er++;
        if (pm_bulk_o === 1'b1) n_bk++;
    end
    // ==========================================
    // scenarios
    task automatic t_regs;
        wb(1'b0, OFF_FLASH_CONTROL, 16'h0, rd_q);
        check(rd_q, {16'h0, FC_RESET});
        wb(1'b1, 8'h20, 16'hFFFF, rd_q);
        wb(1'b0, 8'h20, 16'h0, rd_q);
        check(rd_q, 32'h0);
        wb(1'b1, OFF_WINDOW_PAGE, 16'h0003, rd_q);
        wb(1'b0, OFF_WINDOW_PAGE, 16'h0, rd_q);
        check(rd_q, 32'h3);
        wb(1'b1, OFF_CORE_CONTROL, 16'h0004, rd_q);
    endtask : t_regs
    task automatic t_window;
        win(16'h8124, 3'b100, 1'b1, WIN_EXTRA_MOVE);
        win(16'h8FFE, 3'b000, 1'b1, WIN_EXTRA_OTHER);
        win(16'hC002, 3'b011, 1'b1, WIN_EXTRA_OTHER);
        win(16'h8010, 3'b110, 1'b1, WIN_EXTRA_MOVE);
        win(16'h7FFE, 3'b100, 1'b0, 2'h0);
        wb(1'b1, OFF_CORE_CONTROL, 16'h0000, rd_q);
        win(16'h8124, 3'b100, 1'b0, 2'h0);
        wb(1'b1, OFF_CORE_CONTROL, 16'h0004, rd_q);
    endtask : t_window
    task automatic t_table;
        tpage = 8'h12;
        wb(1'b1, OFF_TABLE_PAGE, 16'h0012, rd_q);
        tbl(3'b000, 16'h0456, 16'h0, q);
        check(32'(q), 32'h022B);
        tbl(3'b001, 16'h0457, 16'h0, q);
        check(32'(q), 32'h0002);
        tbl(3'b010, 16'h0456, 16'h0, q);
        check(32'(q), 32'h005A);
        tbl(3'b011, 16'h0456, 16'h0, q);
        check(32'(q), 32'h005A);
        tbl(3'b011, 16'h0457, 16'h0, q);
        check(32'(q), 32'h0000);
    endtask : t_table
    task automatic t_flash;
        op(1'b0, 16'hC001, 16'h6001, 2'b00);
        wb(1'b1, OFF_FLASH_UNLOCK_KEY, {8'h00, KEY_FIRST}, rd_q);
        wb(1'b1, OFF_WINDOW_PAGE, 16'h0003, rd_q);
        wb(1'b1, OFF_FLASH_UNLOCK_KEY, {8'h00, KEY_SECOND}, rd_q);
        op(1'b0, 16'hC001, 16'h6001, 2'b00);
        op(1'b1, 16'h8001, 16'h2001, 2'b00);
        check(32'(n_wr), 32'h0);
        tpage = 8'h00;
        wb(1'b1, OFF_TABLE_PAGE, 16'h0000, rd_q);
        for (int k = 0; k < ROW_WORDS; k++) begin
            tbl(3'b100, 16'h0180 + 16'(2 * k), 16'hA000 + 16'(k), q);
            tbl(3'b110, 16'h0180 + 16'(2 * k), 16'h00FF, q);
        end
        tbl(3'b000, 16'h018A, 16'h0, q);
        check(32'(q), 32'h00C5);
        row_mode = 1'b1;
        op(1'b1, 16'hC001, 16'h4001, 2'b01);
        row_mode = 1'b0;
        check(32'(n_wr), 32'd64);
        tbl(3'b000, 16'h018A, 16'h0, q);
        check(32'(q), 32'hA005);
        op(1'b1, 16'hC003, 16'h4003, 2'b01);
        check(32'(n_wr), 32'd65);
        op(1'b1, 16'hC042, 16'h4042, 2'b01);
        check(32'(n_er), 32'd1);
        op(1'b1, 16'hC044, 16'h4044, 2'b10);
        op(1'b1, 16'hC00F, 16'h400F, 2'b10);
        check(32'(n_wr + n_er), 32'd66);
        op(1'b1, 16'hC04F, 16'h404F, 2'b01);
        check(32'(n_bk), 32'd1);
    endtask : t_flash
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_regs();
        t_window();
        t_table();
        t_flash();
        tally_and_finish();
    end
endmodule : testbench
